// ### src/ctc_pkg.sv
/*
 * ctc_pkg: shared constants and types for the charger and thermal control block.
 * Assumes a 250 MHz system clock; analog comparators feed level inputs to the block.
 */
`default_nettype none
package ctc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] CTC_ADDR_HOLD_CTRL = 8'h1c;
    localparam logic [7:0] CTC_ADDR_CHG_CTRL1 = 8'h10;
    localparam logic [7:0] CTC_ADDR_CHG_CTRL2 = 8'h11;
    localparam logic [7:0] CTC_ADDR_CHG_CTRL3 = 8'h12;
    localparam logic [7:0] CTC_ADDR_STATUS    = 8'h0c;
    localparam logic [7:0] CTC_ADDR_REG_A     = 8'h03;
    localparam logic [7:0] CTC_ADDR_REG_B     = 8'h04;

    localparam int CTC_BIT_AUTO_RESTART = 1;
    localparam int CTC_BIT_HOLD_DELAY   = 0;
    localparam int CTC_BIT_SHDN_FLAG    = 3;
    localparam int CTC_BIT_WARN_FLAG    = 2;

    // ****************************************************************
    // reset values and code limits
    // ****************************************************************
    localparam logic [7:0] CTC_RST_HOLD_CTRL = 8'h00;
    localparam logic [4:0] CTC_ICHG_DEFAULT  = 5'h07;
    localparam logic [4:0] CTC_ICHG_MAX      = 5'h17;
    localparam logic [1:0] CTC_TERMINATION_VOLTAGE_CODE_DEFAULT = 2'h1;
    localparam logic [1:0] CTC_EOC_DEFAULT   = 2'h2;
    localparam logic [1:0] CTC_RSTRT_DEFAULT = 2'h1;
    localparam logic [1:0] CTC_TIMER_DEFAULT = 2'h2;
    localparam logic [4:0] CTC_VCODE_LOW     = 5'h0c;
    localparam logic [4:0] CTC_VCODE_HIGH    = 5'h1b;
    localparam logic [4:0] CTC_VCODE_MAXLIN1 = 5'h0e;
    localparam logic [4:0] CTC_VCODE_LIN2LO  = 5'h13;
    localparam logic [4:0] CTC_VCODE_LIN2HI  = 5'h1d;

    // ****************************************************************
    // electrical figures, in mA and mV
    // ****************************************************************
    localparam logic [10:0] CTC_ICHG_STEP_MA  = 11'h032;
    localparam logic [10:0] CTC_PRECHG_MA     = 11'h032;
    localparam logic [12:0] CTC_TERMINATION_VOLTAGE_CODE_BASE_MV = 13'h1004;
    localparam logic [12:0] CTC_TERMINATION_VOLTAGE_CODE_STEP_MV = 13'h0064;
    localparam logic [12:0] CTC_RSTRT_STEP_MV = 13'h0032;
    localparam logic [11:0] CTC_VREG_BASE_MV  = 12'h4b0;
    localparam logic [11:0] CTC_VREG_STEP_MV  = 12'h032;
    localparam logic [11:0] CTC_VREG_2V00     = 12'h7d0;
    localparam logic [11:0] CTC_VREG_2V20     = 12'h898;
    localparam logic [11:0] CTC_VREG_2V40     = 12'h960;
    localparam logic [11:0] CTC_VREG_2V50     = 12'h9c4;
    localparam logic [11:0] CTC_VREG_2V60     = 12'ha28;
    localparam logic [11:0] CTC_VREG_3V20     = 12'hc80;
    localparam logic [11:0] CTC_VREG_3V30     = 12'hce4;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam longint CTC_CLK_HZ       = 250_000_000;
    localparam longint CTC_HOLD_SHORT_MS = 35;
    localparam longint CTC_HOLD_LONG_MS  = 350;
    localparam longint CTC_HOLD_SHORT_CYC = CTC_HOLD_SHORT_MS * CTC_CLK_HZ / 1000;
    localparam longint CTC_HOLD_LONG_CYC  = CTC_HOLD_LONG_MS * CTC_CLK_HZ / 1000;
    localparam longint CTC_HOURS_2 = 2;
    localparam longint CTC_HOURS_5 = 5;
    localparam longint CTC_HOURS_8 = 8;
    localparam longint CTC_SEC_PER_HOUR = 3600;

    typedef enum logic [2:0] {
        CHG_IDLE, CHG_PRE, CHG_CC, CHG_CV, CHG_MAINT, CHG_FAULT
    } ctc_chg_state_t;

    typedef struct packed {
        logic over_shutdown;   // die above 160 C
        logic below_restart;   // die below 90 C
        logic over_warn;       // die above 105 C
        logic below_warn_hyst; // die below 90 C warning release
        logic over_regulation; // die above 115 C
    } ctc_temp_t;

    typedef struct packed {
        logic charger_ok;      // valid charger input
        logic batt_present;
        logic batt_above_pre;  // battery above 2.8 V
        logic batt_at_term;    // battery at termination level
        logic curr_below_eoc;  // current below end threshold
        logic batt_below_rst;  // battery below restart level
    } ctc_batt_t;

    typedef struct packed {
        logic [10:0] current_ma;
        logic [12:0] term_mv;
        logic [12:0] restart_mv;
        logic [10:0] eoc_ma;
        logic        reduce;
    } ctc_chg_out_t;
endpackage : ctc_pkg
`default_nettype wire

// ### src/ctc_top.sv
/*
 * ctc_top: charger sequencing, thermal flags, hold release and regulator code decode.
 * Assumes the serial access block delivers single-cycle write strobes and reads the
 * read data combinationally; analog comparator outputs are synchronous levels.
 */
//
// Notes on behaviour
// RQ1 - auto restart bit decides whether shutdown recovery powers up by itself
// RQ2 - power down after hold input low 35 ms, or 350 ms when selected
// RQ3 - codes 00-0e are 1.20-1.90 V by 50 mV, then 2.00/2.20/2.40/2.50 V
// RQ4 - codes 13-1d are 2.60-3.10 V, 1e 3.20 V, 1f 3.3 V; defaults 0c/1b
// RQ5 - charge current is 50 mA plus 50 mA per code, default 400 mA
// RQ6 - termination voltage 4.1/4.2/4.3/4.4 V, default 4.2 V
// RQ7 - end-of-charge threshold 0.05/0.1/0.15/0.2 of charge current, default 0.15
// RQ8 - restart level is termination minus 50/100/150/200 mV, default 100 mV
// RQ9 - safety timer off, 2, 5 or 8 hours, default 5 hours
// RQ10 - valid charger input starts pre-charge at 50 mA until 2.8 V
// RQ11 - above 2.8 V charge at programmed current until termination voltage
// RQ12 - at termination hold voltage, then maintenance when current reaches threshold
// RQ13 - in maintenance a drop to restart level starts a new charge cycle
// RQ14 - host rewrites charge current after a battery is attached late
// RQ15 - battery judged absent at start selects the battery-absent default current
// RQ16 - above 160 C set shutdown flag and run power down
// RQ17 - no restart or power on until die is below 90 C
// RQ18 - without auto restart wait for button, charger input or bus power
// RQ19 - with auto restart power up after cooling, keeping register settings
// RQ20 - warning flag sets above 105 C, clears only below 90 C
// RQ21 - above 115 C charger reduces its current
// RQ22 - power down end restores all registers except charger controls; the code also keeps the status flags
`default_nettype none
module ctc_top
    import ctc_pkg::*;
#(
    parameter longint HOLD_SHORT_CYC = ctc_pkg::CTC_HOLD_SHORT_CYC,
    parameter longint HOLD_LONG_CYC  = ctc_pkg::CTC_HOLD_LONG_CYC,
    parameter longint TIMER_TICK_CYC = ctc_pkg::CTC_CLK_HZ
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  reg_wr_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    output logic [7:0]                 reg_rdata_o,
    input  wire logic                  power_hold_input_i,
    input  wire logic                  power_button_input_i,
    input  wire logic                  charger_input_i,
    input  wire logic                  bus_power_i,
    input  wire ctc_pkg::ctc_temp_t    temp_i,
    input  wire ctc_pkg::ctc_batt_t    batt_i,
    output ctc_pkg::ctc_chg_out_t      chg_o,
    output ctc_pkg::ctc_chg_state_t    chg_state_o,
    output logic                       charge_timeout_o,
    output logic                       power_on_o,
    output logic                       power_down_o,
    output logic [11:0]                vreg_a_mv_o,
    output logic [11:0]                vreg_b_mv_o,
    output logic [4:0]                 vreg_a_code_o,
    output logic [4:0]                 vreg_b_code_o
);
    import ctc_pkg::*;

    // ****************************************************************
    // decode functions
    // ****************************************************************
    function automatic logic [11:0] vcode_mv(input logic [4:0] c);
        logic [11:0] v;
        v = CTC_VREG_3V30;
        if (c <= CTC_VCODE_MAXLIN1) begin // see RQ3
            v = CTC_VREG_BASE_MV + 12'(c) * CTC_VREG_STEP_MV;
        end else if (c < CTC_VCODE_LIN2LO) begin // see RQ3
            unique case (c[1:0])
                2'h3:    v = CTC_VREG_2V00;
                2'h0:    v = CTC_VREG_2V20;
                2'h1:    v = CTC_VREG_2V40;
                default: v = CTC_VREG_2V50;
            endcase
        end else if (c <= CTC_VCODE_LIN2HI) begin // see RQ4
            v = CTC_VREG_2V60 + 12'(c - CTC_VCODE_LIN2LO) * CTC_VREG_STEP_MV;
        end else if (c == CTC_VCODE_LIN2HI + 5'h01) begin // see RQ4
            v = CTC_VREG_3V20;
        end
        return v;
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]  hold_ctrl_ff;
    logic [4:0]  ichg_ff;
    logic [1:0]  termination_voltage_code_ff, eoc_ff, rstrt_ff, timer_ff;
    logic [4:0]  vcode_a_ff, vcode_b_ff;
    logic        shdn_flag_ff, warn_flag_ff;
    logic        pd_end;
    logic        started_ff;

    logic wr_hold, wr_c1, wr_c2, wr_c3;
    assign wr_hold = reg_wr_i && (reg_addr_i == CTC_ADDR_HOLD_CTRL);
    assign wr_c1   = reg_wr_i && (reg_addr_i == CTC_ADDR_CHG_CTRL1);
    assign wr_c2   = reg_wr_i && (reg_addr_i == CTC_ADDR_CHG_CTRL2);
    assign wr_c3   = reg_wr_i && (reg_addr_i == CTC_ADDR_CHG_CTRL3);

    // hold control and regulator code registers fall back to defaults when a power down completes, except after an overtemp one with auto restart set
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || pd_end) begin // see RQ22
            hold_ctrl_ff <= CTC_RST_HOLD_CTRL;
            vcode_a_ff   <= CTC_VCODE_LOW; // see RQ4
            vcode_b_ff   <= CTC_VCODE_HIGH;
        end else begin
            if (wr_hold) hold_ctrl_ff <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == CTC_ADDR_REG_A) vcode_a_ff <= reg_wdata_i[4:0];
            if (reg_wr_i && reg_addr_i == CTC_ADDR_REG_B) vcode_b_ff <= reg_wdata_i[4:0];
        end
    end

    // charger controls survive power down; battery-absent start picks the max code
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ichg_ff    <= CTC_ICHG_DEFAULT; // see RQ5
            termination_voltage_code_ff   <= CTC_TERMINATION_VOLTAGE_CODE_DEFAULT; // see RQ6
            eoc_ff     <= CTC_EOC_DEFAULT; // see RQ7
            rstrt_ff   <= CTC_RSTRT_DEFAULT; // see RQ8
            timer_ff   <= CTC_TIMER_DEFAULT; // see RQ9
            started_ff <= 1'b0;
        end else begin
            started_ff <= 1'b1;
            if (!started_ff && !batt_i.batt_present) ichg_ff <= CTC_ICHG_MAX; // see RQ15
            else if (wr_c2) ichg_ff <= (reg_wdata_i[4:0] > CTC_ICHG_MAX) ? CTC_ICHG_MAX : reg_wdata_i[4:0];
            if (wr_c1) timer_ff <= reg_wdata_i[4:3];
            if (wr_c3) begin
                termination_voltage_code_ff <= reg_wdata_i[5:4];
                eoc_ff   <= reg_wdata_i[3:2];
                rstrt_ff <= reg_wdata_i[1:0];
            end
        end
    end

    always_comb begin
        reg_rdata_o = 8'h00;
        unique case (reg_addr_i)
            CTC_ADDR_HOLD_CTRL: reg_rdata_o = hold_ctrl_ff;
            CTC_ADDR_CHG_CTRL1: reg_rdata_o = {3'h0, timer_ff, 3'h0};
            CTC_ADDR_CHG_CTRL2: reg_rdata_o = {3'h0, ichg_ff};
            CTC_ADDR_CHG_CTRL3: reg_rdata_o = {2'h0, termination_voltage_code_ff, eoc_ff, rstrt_ff};
            CTC_ADDR_STATUS:    reg_rdata_o = 8'(shdn_flag_ff) << CTC_BIT_SHDN_FLAG |
                                              8'(warn_flag_ff) << CTC_BIT_WARN_FLAG;
            CTC_ADDR_REG_A:     reg_rdata_o = {3'h0, vcode_a_ff};
            CTC_ADDR_REG_B:     reg_rdata_o = {3'h0, vcode_b_ff};
            default:            reg_rdata_o = 8'h00;
        endcase
    end

    logic auto_restart, hold_delay_sel;
    assign auto_restart   = hold_ctrl_ff[CTC_BIT_AUTO_RESTART];
    assign hold_delay_sel = hold_ctrl_ff[CTC_BIT_HOLD_DELAY];

    // ****************************************************************
    // thermal flags and power state
    // ****************************************************************
    logic power_on_ff, pd_ff;
    logic trigger;
    assign trigger = power_button_input_i || charger_input_i || bus_power_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            warn_flag_ff <= 1'b0;
        end else if (temp_i.over_warn) begin
            warn_flag_ff <= 1'b1; // see RQ20
        end else if (temp_i.below_warn_hyst) begin
            warn_flag_ff <= 1'b0; // see RQ20
        end
    end

    // hold counter: long counts are parameters so simulation can shrink them
    logic [27:0] hold_cnt_ff;
    logic [27:0] hold_lim;
    logic        hold_expired;
    assign hold_lim     = hold_delay_sel ? 28'(HOLD_LONG_CYC) : 28'(HOLD_SHORT_CYC);
    assign hold_expired = power_on_ff && !power_hold_input_i && (hold_cnt_ff >= hold_lim - 28'h1);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || power_hold_input_i || !power_on_ff) hold_cnt_ff <= 28'h0;
        else if (!hold_expired) hold_cnt_ff <= hold_cnt_ff + 28'h1; // see RQ2
    end

    logic power_up_req;
    // flag is kept through power down (it is a status bit, set wins)
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            shdn_flag_ff <= 1'b0;
        end else if (temp_i.over_shutdown) begin
            shdn_flag_ff <= 1'b1; // see RQ16
        end else if (power_up_req) begin
            shdn_flag_ff <= 1'b0;
        end
    end

    assign power_up_req = !power_on_ff && !pd_ff && temp_i.below_restart && // see RQ17
                          (trigger || (shdn_flag_ff && auto_restart)); // see RQ1 see RQ18 see RQ19

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            power_on_ff <= 1'b0;
            pd_ff       <= 1'b0;
        end else if (pd_ff) begin
            pd_ff       <= 1'b0;
        end else if (power_on_ff && (temp_i.over_shutdown || hold_expired)) begin
            power_on_ff <= 1'b0; // see RQ16 see RQ2
            pd_ff       <= 1'b1;
        end else if (power_up_req) begin
            power_on_ff <= 1'b1;
        end
    end
    // auto restart keeps settings: every power down resets them except an overtemp one with auto restart set
    assign pd_end       = pd_ff && !(shdn_flag_ff && auto_restart); // see RQ19
    assign power_on_o   = power_on_ff;
    assign power_down_o = pd_ff;

    // ****************************************************************
    // charger sequencer
    // ****************************************************************
    ctc_chg_state_t state_ff;
    // eight hours counted in seconds needs 15 bits
    logic [14:0] sec_cnt_ff;
    logic [27:0] tick_cnt_ff;
    logic        timeout_ff;
    logic [14:0] timer_lim;
    always_comb begin
        unique case (timer_ff) // see RQ9
            2'h1:    timer_lim = 15'(CTC_HOURS_2 * CTC_SEC_PER_HOUR);
            2'h2:    timer_lim = 15'(CTC_HOURS_5 * CTC_SEC_PER_HOUR);
            2'h3:    timer_lim = 15'(CTC_HOURS_8 * CTC_SEC_PER_HOUR);
            default: timer_lim = 15'h0;
        endcase
    end
    logic charging;
    assign charging = state_ff inside {CHG_PRE, CHG_CC, CHG_CV};

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || !charging) begin
            tick_cnt_ff <= 28'h0;
            sec_cnt_ff  <= 15'h0;
        end else if (tick_cnt_ff == 28'(TIMER_TICK_CYC) - 28'h1) begin
            tick_cnt_ff <= 28'h0;
            sec_cnt_ff  <= sec_cnt_ff + 15'h1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 28'h1;
        end
    end

    logic tmo;
    assign tmo = (timer_ff != 2'h0) && (sec_cnt_ff >= timer_lim); // see RQ9

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state_ff   <= CHG_IDLE;
            timeout_ff <= 1'b0;
        end else if (!batt_i.charger_ok || temp_i.over_shutdown) begin
            state_ff <= CHG_IDLE;
            timeout_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                CHG_IDLE:  state_ff <= CHG_PRE; // see RQ10
                CHG_PRE:   if (batt_i.batt_above_pre) state_ff <= CHG_CC; // see RQ11
                CHG_CC:    if (batt_i.batt_at_term) state_ff <= CHG_CV; // see RQ12
                CHG_CV:    if (batt_i.curr_below_eoc) state_ff <= CHG_MAINT; // see RQ12
                CHG_MAINT: if (batt_i.batt_below_rst) state_ff <= CHG_PRE; // see RQ13
                CHG_FAULT: state_ff <= CHG_FAULT;
            endcase
            if (charging && tmo) begin
                state_ff   <= CHG_FAULT;
                timeout_ff <= 1'b1;
            end
        end
    end

    logic [10:0] prog_ma;
    assign prog_ma = CTC_ICHG_STEP_MA + 11'(ichg_ff) * CTC_ICHG_STEP_MA; // see RQ5
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            chg_o <= '0;
        end else begin
            chg_o.current_ma <= (state_ff == CHG_PRE) ? CTC_PRECHG_MA : // see RQ10
                                (state_ff inside {CHG_CC, CHG_CV}) ? prog_ma : 11'h0; // see RQ11
            chg_o.term_mv    <= CTC_TERMINATION_VOLTAGE_CODE_BASE_MV + 13'(termination_voltage_code_ff) * CTC_TERMINATION_VOLTAGE_CODE_STEP_MV; // see RQ6
            chg_o.restart_mv <= CTC_TERMINATION_VOLTAGE_CODE_BASE_MV + 13'(termination_voltage_code_ff) * CTC_TERMINATION_VOLTAGE_CODE_STEP_MV
                                - (13'(rstrt_ff) + 13'h1) * CTC_RSTRT_STEP_MV; // see RQ8
            chg_o.eoc_ma     <= 11'((22'(prog_ma) * (22'(eoc_ff) + 22'h1)) / 22'h14); // see RQ7
            chg_o.reduce     <= temp_i.over_regulation; // see RQ21
        end
    end
    assign chg_state_o      = state_ff;
    assign charge_timeout_o = timeout_ff;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            vreg_a_mv_o <= 12'h0;
            vreg_b_mv_o <= 12'h0;
        end else begin
            vreg_a_mv_o <= vcode_mv(vcode_a_ff); // see RQ3
            vreg_b_mv_o <= vcode_mv(vcode_b_ff); // see RQ4
        end
    end
    assign vreg_a_code_o = vcode_a_ff;
    assign vreg_b_code_o = vcode_b_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    shdn_sets_flag_a: assert property (temp_i.over_shutdown |=> shdn_flag_ff) // see RQ16
        else $error("shutdown flag not set");
    shdn_powers_down_a: assert property (power_on_ff && temp_i.over_shutdown |=> pd_ff && !power_on_ff) // see RQ16
        else $error("no power down on overtemp");
    hot_no_power_a: assert property (!power_on_ff && !temp_i.below_restart |=> !power_on_ff) // see RQ17
        else $error("power on while hot");
    warn_sets_a: assert property (temp_i.over_warn |=> warn_flag_ff) // see RQ20
        else $error("warning flag not set");
    warn_holds_a: assert property (warn_flag_ff && !temp_i.below_warn_hyst |=> warn_flag_ff) // see RQ20
        else $error("warning cleared early");
    pre_to_cc_a: assert property (state_ff == CHG_PRE && batt_i.batt_above_pre && batt_i.charger_ok
        && !temp_i.over_shutdown && !tmo |=> state_ff == CHG_CC) // see RQ11
        else $error("no full rate after precharge");
    pre_current_a: assert property (state_ff == CHG_PRE |=> chg_o.current_ma == CTC_PRECHG_MA) // see RQ10
        else $error("precharge current wrong");
    maint_restart_a: assert property (state_ff == CHG_MAINT && batt_i.batt_below_rst && batt_i.charger_ok
        && !temp_i.over_shutdown |=> state_ff == CHG_PRE) // see RQ13
        else $error("no recharge from maintenance");
    regulate_a: assert property (temp_i.over_regulation |=> chg_o.reduce) // see RQ21
        else $error("no current reduction");
    no_auto_a: assert property (!power_on_ff && !pd_ff && !trigger && !auto_restart |=> !power_on_ff) // see RQ1
        else $error("unexpected automatic start");
    // a few low cycles must not release the hold yet; short delay is far longer
    sequence hold_high_s;
        power_on_ff && power_hold_input_i && !hold_delay_sel && !temp_i.over_shutdown;
    endsequence
    sequence hold_low_s;
        !power_hold_input_i && !temp_i.over_shutdown && !hold_delay_sel && !wr_hold;
    endsequence
    hold_short_a: assert property (hold_high_s ##1 hold_low_s[*8] |=> power_on_ff) // see RQ2
        else $error("power down too early");
endmodule : ctc_top
`default_nettype wire

// ### tb/ctc_host.sv
/* ctc_host: host processor model that writes and reads the control registers.
   assumes writes are taken on a rising edge and read data is combinational. */
`default_nettype none
module ctc_host (
    input  wire logic       clk_i,
    output logic            wr_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    input  wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_o, addr_o, wdata_o} = 17'h0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        #1 d = rdata_i;
    endtask
    // a late battery keeps the no-battery current until written again
    task automatic reattach(input logic [4:0] code);
        wr(8'h11, {3'h0, code});
    endtask
endmodule // ctc_host
`default_nettype wire

// ### tb/testbench.sv
/* testbench: drives ctc_top through the host model, comparator levels and triggers.
   assumes shortened hold and timer counts set at the instance. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ctc_pkg::*;
    localparam int HS = 20;
    localparam int HL = 40;
    logic clk = 1'b0, rstn = 1'b0, hold = 1'b1, btn = 1'b0, chgin = 1'b0, vbus = 1'b0, wr;
    logic [7:0]     addr, wdata, rdata, rb, v;
    logic [11:0]    mva, mvb;
    logic [4:0]     ca, cb;
    logic [10:0]    ima;
    ctc_temp_t      temp = '0;
    ctc_batt_t      batt = '0;
    ctc_chg_out_t   chg;
    ctc_chg_state_t st;
    logic           tmo, pon, pdn;
    int             error_cnt = 0, checks = 0, cyc = 0, k;
    logic [15:0]    dflt [7] = '{16'h1c00, 16'h1107, 16'h1219, 16'h030c, 16'h041b, 16'h2000, 16'h1010};
    always #2 clk = ~clk;
    ctc_host i_ctc_host (.clk_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));
    ctc_top #(.HOLD_SHORT_CYC(HS), .HOLD_LONG_CYC(HL), .TIMER_TICK_CYC(4)) i_ctc_top (
        .sys_clk_i(clk), .rstn_i(rstn), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .power_hold_input_i(hold), .power_button_input_i(btn),
        .charger_input_i(chgin), .bus_power_i(vbus), .temp_i(temp), .batt_i(batt), .chg_o(chg),
        .chg_state_o(st), .charge_timeout_o(tmo), .power_on_o(pon), .power_down_o(pdn),
        .vreg_a_mv_o(mva), .vreg_b_mv_o(mvb), .vreg_a_code_o(ca), .vreg_b_code_o(cb));
    // ******
    // helpers
    // ******
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic smp(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [11:0] vmv(input logic [4:0] c);
        if (c <= 5'h0e) return 12'h4b0 + 12'h032 * c;
        if (c >= 5'h13 && c <= 5'h1d) return 12'ha28 + 12'h032 * (c - 5'h13);
        case (c)
            5'h0f: return 12'h7d0;
            5'h10: return 12'h898;
            5'h11: return 12'h960;
            5'h12: return 12'h9c4;
            5'h1e: return 12'hc80;
            default: return 12'hce4;
        endcase
    endfunction
    // the run takes about 30k cycles, mostly the two hour safety timer
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h99eb44ec));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        i_ctc_host.rd(8'h11, rb);
        chk(rb, 8'h17);
        i_ctc_host.reattach(5'h07);
        i_ctc_host.rd(8'h11, rb);
        chk(rb, 8'h07);
        @(posedge clk) {rstn, batt.batt_present} <= 2'b01;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        foreach (dflt[i]) begin
            i_ctc_host.rd(dflt[i][15:8], rb);
            chk(rb, dflt[i][7:0]);
        end
        $display("defaults done");
        for (int c = 0; c < 32; c++) begin
            k = $urandom_range(31);
            i_ctc_host.wr(8'h03, c[7:0]);
            i_ctc_host.wr(8'h04, k[7:0]);
            smp(1);
            chk(mva, vmv(c[4:0]));
            chk(mvb, vmv(k[4:0]));
            chk({ca, cb}, {c[4:0], k[4:0]});
        end
        $display("regulator done");
        k = 2 * $urandom_range(11) + 1;
        ima = 11'h032 * (k[10:0] + 11'h001);
        v = $urandom;
        i_ctc_host.wr(8'h11, 8'h1f);
        i_ctc_host.rd(8'h11, rb);
        chk(rb, 8'h17);
        i_ctc_host.wr(8'h11, k[7:0]);
        i_ctc_host.wr(8'h12, {2'h0, v[5:0]});
        batt.charger_ok <= 1'b1;
        smp(3);
        chk(st, CHG_PRE);
        chk(chg.current_ma, 11'h032);
        chk(chg.term_mv, 13'h1004 + 13'h0064 * v[5:4]);
        chk(chg.restart_mv, 13'h1004 + 13'h0064 * v[5:4] - 13'h0032 * (v[1:0] + 13'h1));
        @(posedge clk) {batt.batt_above_pre, temp.over_regulation} <= 2'b11;
        smp(3);
        chk(st, CHG_CC);
        chk(chg.current_ma, ima);
        chk(chg.eoc_ma, ima * (v[3:2] + 16'h1) * 16'h5 / 16'h64);
        chk(chg.reduce, 1'b1);
        @(posedge clk) {batt.batt_at_term, temp.over_regulation} <= 2'b10;
        smp(3);
        chk(st, CHG_CV);
        @(posedge clk) batt.curr_below_eoc <= 1'b1;
        smp(3);
        chk(st, CHG_MAINT);
        @(posedge clk) batt[3:0] <= 4'h1;
        smp(1);
        chk(st, CHG_PRE);
        i_ctc_host.wr(8'h10, 8'h08);
        batt <= 6'h10;
        smp(2);
        batt.charger_ok <= 1'b1;
        smp(28600);
        chk(tmo, 1'b0);
        smp(400);
        chk(tmo, 1'b1);
        $display("charger done");
        @(posedge clk) {btn, temp} <= {1'b1, 5'h08};
        smp(3);
        chk(pon, 1'b1);
        btn <= 1'b0;
        temp <= 5'h04;
        i_ctc_host.rd(8'h0c, rb);
        temp <= 5'h00;
        chk(rb[2], 1'b1);
        i_ctc_host.rd(8'h0c, rb);
        chk(rb[2], 1'b1);
        temp <= 5'h02;
        smp(2);
        i_ctc_host.rd(8'h0c, rb);
        chk(rb[2], 1'b0);
        i_ctc_host.wr(8'h03, 8'h05);
        temp <= 5'h10;
        smp(1);
        chk(pdn, 1'b1);
        temp <= 5'h08;
        smp(10);
        chk(pon, 1'b0);
        i_ctc_host.rd(8'h0c, rb);
        chk(rb[3], 1'b1);
        i_ctc_host.rd(8'h03, rb);
        chk(rb, 8'h0c);
        i_ctc_host.rd(8'h11, rb);
        chk(rb, k[7:0]);
        @(posedge clk) btn <= 1'b1;
        i_ctc_host.wr(8'h1c, 8'h02);
        {btn, temp} <= {1'b0, 5'h10};
        smp(3);
        temp <= 5'h00;
        smp(10);
        chk(pon, 1'b0);
        temp <= 5'h08;
        smp(3);
        chk(pon, 1'b1);
        i_ctc_host.rd(8'h1c, rb);
        chk(rb, 8'h02);
        $display("thermal done");
        for (int d = 0; d < 2; d++) begin
            i_ctc_host.wr(8'h1c, d[7:0]);
            hold <= 1'b0;
            k = 0;
            while (pdn !== 1'b1 && k < 100) begin
                smp(1);
                k++;
            end
            chk(k >= (d ? HL : HS) && k <= (d ? HL : HS) + 2, 1'b1);
            @(posedge clk) {hold, chgin, vbus} <= {1'b1, d == 0, d == 1};
            smp(3);
            chk(pon, 1'b1);
            {chgin, vbus} <= 2'b00;
        end
        $display("hold done");
        test_done();
    end
endmodule // testbench
`default_nettype wire
